// ---- rtl/cfg_store_defs.svh ----
// Purpose: Named constants for the configuration store and its interface setup
// Assumes: 250 MHz core clock
// Notes: Included by the package and by the design modules
`ifndef CFG_STORE_DEFS_SVH
`define CFG_STORE_DEFS_SVH

`define WORD_W 16
`define IDX_W 6
`define STORE_DEPTH 64
`define CUST_LAST_IDX 6'h39
`define WORD_RESET 16'h0000
`define WORD_IDENT_LOW 6'h00
`define WORD_IDENT_HIGH 6'h01
`define WORD_IFACE 6'h02

`define CMD_WRITE_FIRST 8'h40
`define CMD_WRITE_LAST 8'h79
`define CMD_READ_FIRST 8'h00
`define CMD_READ_LAST 8'h39

`define F_ADDR_HI 6
`define F_ADDR_LO 0
`define F_INT_HI 8
`define F_INT_LO 7
`define F_SEL_POL 9
`define F_CLK_HI 11
`define F_CLK_LO 10

`define INT_EOC 2'h0
`define INT_ABOVE 2'h1
`define INT_BELOW 2'h2
`define INT_WINDOW 2'h3

`define HS_FIRST_ADDR 7'h04
`define HS_LAST_ADDR 7'h07
`define TENBIT_PREFIX 5'h1e
`define CMD_BYTES 2'h3
`define BYTE_CNT_ZERO 2'h0
`define BYTE_CNT_ONE 2'h1
`define BYTE_CNT_TWO 2'h2

`define RES_W 24
`define PROG_TIME_NS 16000000
`define CLK_PERIOD_NS 4
`define PROG_CYCLES (`PROG_TIME_NS / `CLK_PERIOD_NS)
`define PROG_CNT_W 22

`endif

// ---- rtl/cfg_store_pkg.sv ----
// Purpose: Types shared by the configuration store modules
// Assumes: cfg_store_defs.svh supplies the word and index widths
// Notes: Structs carry grouped signals between modules
`include "cfg_store_defs.svh"

package cfg_store_pkg;

  typedef struct packed {
    logic [1:0] clock_shape;
    logic select_high;
    logic [1:0] int_mode;
    logic [6:0] target_addr;
  } iface_cfg_t;

  typedef struct packed {
    logic en;
    logic [`IDX_W-1:0] index;
    logic [`WORD_W-1:0] data;
  } word_wr_t;

  typedef struct packed {
    logic [7:0] code;
    logic [`WORD_W-1:0] data;
  } cmd_t;

  typedef enum logic [0:0] {
    PROG_IDLE = 1'b0,
    PROG_BUSY = 1'b1
  } prog_state_t;

  typedef enum logic [0:0] {
    FE_LOAD = 1'b0,
    FE_READY = 1'b1
  } fe_state_t;

endpackage

// ---- rtl/config_memory_and_interface_setup.sv ----
// Purpose: Rewritable configuration store, command front end, end-of-conversion pin
// Assumes: Byte shifter on the same clock delivers address and data bytes
// Notes: Select pin is asynchronous and passes a two-stage synchroniser
//
// Behaviour
// R1 - Mandatory bus features; no stretching, no 10-bit
// R2 - High-speed mode commands always carry three bytes
// R3 - Store holds 16-bit rewritable customer words
// R4 - Customer writes use command codes 40h to 79h
// R5 - Trim sector writable only by factory flow
// R6 - Word write finishes within 16 ms
// R7 - Host reads back written words to verify
// R8 - Words 0 and 1 form customer identifier
// R9 - Word 2 bits 6:0 set target address
// R10 - Word 2 bits 8:7 select pin function
// R11 - Codes 01/10 track crossing of threshold one
// R12 - Code 11, t1>t2: low inside band, else high
// R13 - Code 11, t1<=t2: high inside band, else low
// R14 - Word 2 bit 9 sets select polarity
// R15 - End-of-conversion: pin high after measurement completes
// R16 - Word 2 bits 11:10 set clock shape
// R17 - Busy while programming; commands not processed
// R18 - Word 2 loaded into active setup at power-up
`timescale 1ns/1ns
`include "cfg_store_defs.svh"

module config_memory_and_interface_setup
  import cfg_store_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Address byte from the serial shifter
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  output logic addr_ack_r,
  // Command bytes and frame end
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic stop,
  // Read answer
  output logic rd_valid_r,
  output logic [`WORD_W-1:0] rd_data_r,
  output logic busy,
  // Clock line, never held low by this target
  output logic scl_out,
  output logic scl_oe,
  // Factory test flow write port
  input wire logic trim_wr_en,
  input wire logic [`IDX_W-1:0] trim_index,
  input wire logic [`WORD_W-1:0] trim_data,
  // Measurement results
  input wire logic conditioned_result_done,
  input wire logic [`RES_W-1:0] conditioned_result,
  input wire logic [`RES_W-1:0] threshold_one,
  input wire logic [`RES_W-1:0] threshold_two,
  output logic eoc_r,
  // Serial peripheral setup
  input wire logic select_pin,
  output logic spi_selected_r,
  output logic sclk_idle_high,
  output logic latch_falling,
  // Active configuration view
  output logic [2*`WORD_W-1:0] customer_ident_r,
  output logic [6:0] target_addr,
  output logic hs_active_r
);

  // True when lo <= x < hi
  function automatic logic in_band(input logic [`RES_W-1:0] lo,
                                   input logic [`RES_W-1:0] hi,
                                   input logic [`RES_W-1:0] x);
    in_band = (lo <= x) && (x < hi);
  endfunction

  // Cut an iface word into the active configuration
  function automatic iface_cfg_t unpack_cfg(input logic [`WORD_W-1:0] w);
    iface_cfg_t c;
    c.target_addr = w[`F_ADDR_HI:`F_ADDR_LO]; // R9
    c.int_mode = w[`F_INT_HI:`F_INT_LO]; // R10
    c.select_high = w[`F_SEL_POL]; // R14
    c.clock_shape = w[`F_CLK_HI:`F_CLK_LO]; // R16
    unpack_cfg = c;
  endfunction

  fe_state_t fe_r, fe_nxt;
  iface_cfg_t cfg_r, cfg_nxt;
  cmd_t buf_r, buf_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic drop_r, drop_nxt;
  logic hs_nxt;
  logic ack_nxt;
  logic rdv_nxt;
  logic [`WORD_W-1:0] rdd_nxt;
  logic eoc_nxt;
  logic sel_meta_r, sel_sync_r, sel_nxt;
  logic sel_primed_r;
  logic [2*`WORD_W-1:0] ident_nxt;

  word_wr_t wr;
  logic store_busy;
  logic [`IDX_W-1:0] rd_index;
  logic [`WORD_W-1:0] rd_word, ident_low, ident_high, iface_word;
  logic [6:0] addr7;
  logic is_hs_code, is_tenbit, exec, is_write, is_read, cmd_done;

  nv_word_store #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_store (
    .clk(clk),
    .nrst(nrst),
    .wr(wr),
    .trim_unlock(trim_wr_en),
    .busy(store_busy),
    .rd_index(rd_index),
    .rd_word(rd_word),
    .ident_low(ident_low),
    .ident_high(ident_high),
    .iface_word(iface_word)
  );

  // Nothing is served until the setup word is loaded
  assign busy = store_busy || (fe_r == FE_LOAD); // R17 R18

  assign addr7 = addr_byte[7:1];
  assign is_hs_code = (addr7 >= `HS_FIRST_ADDR) && (addr7 <= `HS_LAST_ADDR); // R9
  assign is_tenbit = (addr_byte[7:3] == `TENBIT_PREFIX); // R1

  // A frame runs only on stop, with bytes present and none dropped
  assign exec = stop && !drop_r && (cnt_r != `BYTE_CNT_ZERO) && !busy;
  assign is_write = (buf_r.code >= `CMD_WRITE_FIRST) && (buf_r.code <= `CMD_WRITE_LAST); // R4
  assign is_read = (buf_r.code <= `CMD_READ_LAST);
  // Under high-speed mode a short frame is thrown away whole
  assign cmd_done = exec && (!hs_active_r || cnt_r == `CMD_BYTES); // R2
  assign rd_index = buf_r.code[`IDX_W-1:0];

  always_comb begin
    wr = '0;
    if (trim_wr_en) begin
      // Factory flow owns the port for that cycle
      wr.en = 1'b1; // R5
      wr.index = trim_index;
      wr.data = trim_data;
    end else if (cmd_done && is_write && cnt_r == `CMD_BYTES) begin
      wr.en = 1'b1; // R4
      wr.index = `IDX_W'(buf_r.code - `CMD_WRITE_FIRST);
      wr.data = buf_r.data;
    end
  end

  // Front end: power-up load, byte collection, execution
  always_comb begin
    fe_nxt = fe_r;
    cfg_nxt = cfg_r;
    buf_nxt = buf_r;
    cnt_nxt = cnt_r;
    drop_nxt = drop_r;
    hs_nxt = hs_active_r;
    ack_nxt = 1'b0;
    rdv_nxt = 1'b0;
    rdd_nxt = rd_data_r;
    unique case (fe_r)
      FE_LOAD: begin
        cfg_nxt = unpack_cfg(iface_word); // R18
        fe_nxt = FE_READY;
      end
      FE_READY: begin
        if (addr_valid) begin
          if (is_hs_code) begin
            hs_nxt = 1'b1;
          end else begin
            ack_nxt = !is_tenbit && (addr7 == cfg_r.target_addr); // R1 R9
          end
        end
        if (byte_valid) begin
          if (busy || cnt_r == `CMD_BYTES) begin
            drop_nxt = 1'b1; // R17
          end else begin
            unique case (cnt_r)
              `BYTE_CNT_ZERO: buf_nxt.code = byte_data;
              `BYTE_CNT_ONE: buf_nxt.data[`WORD_W-1:8] = byte_data;
              default: buf_nxt.data[7:0] = byte_data;
            endcase
            cnt_nxt = cnt_r + `BYTE_CNT_ONE;
          end
        end
        if (cmd_done && is_read && !is_write) begin
          rdv_nxt = 1'b1;
          rdd_nxt = rd_word;
        end
        if (stop) begin
          cnt_nxt = `BYTE_CNT_ZERO;
          drop_nxt = 1'b0;
          hs_nxt = 1'b0;
          buf_nxt = '0;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      fe_r <= FE_LOAD;
      cfg_r <= '0;
      buf_r <= '0;
      cnt_r <= `BYTE_CNT_ZERO;
      drop_r <= 1'b0;
      hs_active_r <= 1'b0;
      addr_ack_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= `WORD_RESET;
    end else begin
      fe_r <= fe_nxt;
      cfg_r <= cfg_nxt;
      buf_r <= buf_nxt;
      cnt_r <= cnt_nxt;
      drop_r <= drop_nxt;
      hs_active_r <= hs_nxt;
      addr_ack_r <= ack_nxt;
      rd_valid_r <= rdv_nxt;
      rd_data_r <= rdd_nxt;
    end
  end

  // The target never drives the clock line, so it cannot stretch
  assign scl_out = 1'b0; // R1
  assign scl_oe = 1'b0; // R1

  // End-of-conversion / threshold pin
  always_comb begin
    eoc_nxt = eoc_r;
    unique case (cfg_r.int_mode)
      `INT_EOC: begin
        if (conditioned_result_done) begin
          eoc_nxt = 1'b1; // R10 R15
        end else if (cmd_done) begin
          eoc_nxt = 1'b0;
        end
      end
      `INT_ABOVE: begin
        // Equal to the threshold holds the previous level
        if (conditioned_result_done && conditioned_result > threshold_one) begin
          eoc_nxt = 1'b1; // R11
        end else if (conditioned_result_done && conditioned_result < threshold_one) begin
          eoc_nxt = 1'b0; // R11
        end
      end
      `INT_BELOW: begin
        if (conditioned_result_done && conditioned_result < threshold_one) begin
          eoc_nxt = 1'b1; // R11
        end else if (conditioned_result_done && conditioned_result > threshold_one) begin
          eoc_nxt = 1'b0; // R11
        end
      end
      `INT_WINDOW: begin
        if (conditioned_result_done) begin
          if (threshold_one > threshold_two) begin
            eoc_nxt = !in_band(threshold_two, threshold_one, conditioned_result); // R12
          end else begin
            eoc_nxt = in_band(threshold_one, threshold_two, conditioned_result); // R13
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      eoc_r <= 1'b0;
    end else begin
      eoc_r <= eoc_nxt;
    end
  end

  // Select pin synchroniser, then polarity match
  assign sel_nxt = (sel_sync_r == cfg_r.select_high); // R14
  assign ident_nxt = {ident_high, ident_low}; // R8

  // Right after reset the second stage still holds its reset value, which
  // matches the default active-low polarity; wait one more edge for a real
  // pin sample so an idle pin never shows a false select pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sel_meta_r <= 1'b0;
      sel_sync_r <= 1'b0;
      sel_primed_r <= 1'b0;
      spi_selected_r <= 1'b0;
      customer_ident_r <= '0;
    end else begin
      sel_meta_r <= select_pin;
      sel_sync_r <= sel_meta_r;
      sel_primed_r <= (fe_r == FE_READY);
      spi_selected_r <= sel_nxt && sel_primed_r; // R14
      customer_ident_r <= ident_nxt;
    end
  end

  // Clock shape: 00 and 11 latch on rising, 01 and 10 on falling
  assign sclk_idle_high = cfg_r.clock_shape[1]; // R16
  assign latch_falling = cfg_r.clock_shape[1] ^ cfg_r.clock_shape[0]; // R16
  assign target_addr = cfg_r.target_addr;

endmodule

// ---- rtl/nv_word_store.sv ----
// Purpose: Word store with timed programming and a protected trim sector
// Assumes: One write at a time; caller waits while busy is high
// Notes: Contents return to defaults on nrst, standing in for power-up
`timescale 1ns/1ns
`include "cfg_store_defs.svh"

module nv_word_store
  import cfg_store_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = `PROG_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Write request, taken only while idle
  input word_wr_t wr,
  input wire logic trim_unlock,
  output logic busy,
  // Read side
  input wire logic [`IDX_W-1:0] rd_index,
  output logic [`WORD_W-1:0] rd_word,
  output logic [`WORD_W-1:0] ident_low,
  output logic [`WORD_W-1:0] ident_high,
  output logic [`WORD_W-1:0] iface_word
);

  logic [`WORD_W-1:0] mem_r [`STORE_DEPTH];
  logic [`WORD_W-1:0] mem_nxt [`STORE_DEPTH];
  prog_state_t state_r, state_nxt;
  logic [`PROG_CNT_W-1:0] cnt_r, cnt_nxt;
  word_wr_t pend_r, pend_nxt;
  logic allowed;

  // Trim words sit above the customer sector and need the factory unlock
  assign allowed = (wr.index <= `CUST_LAST_IDX) || trim_unlock; // R3 R5

  always_comb begin
    mem_nxt = mem_r;
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    pend_nxt = pend_r;
    unique case (state_r)
      PROG_IDLE: begin
        if (wr.en && allowed) begin
          pend_nxt = wr;
          cnt_nxt = '0;
          state_nxt = PROG_BUSY;
        end
      end
      PROG_BUSY: begin
        // Commit lands exactly PROG_CYCLES after acceptance, inside the limit
        if (cnt_r == `PROG_CNT_W'(PROG_CYCLES - 1)) begin // R6
          mem_nxt[pend_r.index] = pend_r.data; // R3
          state_nxt = PROG_IDLE;
        end else begin
          cnt_nxt = cnt_r + `PROG_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < `STORE_DEPTH; i++) begin
        mem_r[i] <= `WORD_RESET;
      end
      state_r <= PROG_IDLE;
      cnt_r <= '0;
      pend_r <= '0;
    end else begin
      mem_r <= mem_nxt;
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      pend_r <= pend_nxt;
    end
  end

  assign busy = (state_r == PROG_BUSY); // R17
  assign rd_word = mem_r[rd_index];
  assign ident_low = mem_r[`WORD_IDENT_LOW]; // R8
  assign ident_high = mem_r[`WORD_IDENT_HIGH]; // R8
  assign iface_word = mem_r[`WORD_IFACE];

endmodule

// ---- tb/cfg_host_model.sv ----
// Purpose: Bus controller stand-in delivering address and command bytes
// Assumes: Drives one ns after the rising edge, one byte per cycle
// Notes: Released data lines show the inverted last byte, never a stale copy
`timescale 1ns/1ns
module cfg_host_model (
  // Clock
  input wire logic clk,
  // Byte stream to the block
  output logic addr_valid,
  output logic [7:0] addr_byte,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic stop
);
  initial begin
    addr_valid = 1'b0;
    addr_byte = 8'h55;
    byte_valid = 1'b0;
    byte_data = 8'haa;
    stop = 1'b0;
  end
  task automatic send_addr(input logic [7:0] a);
    @(posedge clk) #1;
    addr_valid = 1'b1;
    addr_byte = a;
    @(posedge clk) #1;
    addr_valid = 1'b0;
    addr_byte = ~a;
  endtask
  // Never more than three bytes; high-speed callers pass three to write, or one to check that a short read is dropped
  task automatic send_cmd(input logic [7:0] code, input logic [15:0] data, input int n);
    logic [7:0] b [3];
    b = '{code, data[15:8], data[7:0]};
    for (int i = 0; i < n; i++) begin
      @(posedge clk) #1;
      byte_valid = 1'b1;
      byte_data = b[i];
    end
    @(posedge clk) #1;
    byte_valid = 1'b0;
    byte_data = ~byte_data;
    stop = 1'b1;
    @(posedge clk) #1;
    stop = 1'b0;
  endtask
endmodule

// ---- tb/cfg_store_properties.sv ----
// Purpose: Port-level properties of the configuration store block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to the design from the testbench top
`timescale 1ns/1ns
module cfg_store_properties #(
  parameter int unsigned PROG_CYCLES = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Watched ports
  input wire logic addr_valid,
  input wire logic [7:0] addr_byte,
  input wire logic addr_ack_r,
  input wire logic stop,
  input wire logic rd_valid_r,
  input wire logic busy,
  input wire logic scl_oe,
  input wire logic trim_wr_en,
  input wire logic conditioned_result_done,
  input wire logic eoc_r,
  input wire logic sclk_idle_high,
  input wire logic latch_falling,
  input wire logic [6:0] target_addr,
  input wire logic hs_active_r
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Length of the current busy run, so the programming time is bounded
  logic [7:0] run_r;
  logic [7:0] run_nxt;
  always_comb run_nxt = busy ? run_r + 8'h01 : 8'h00;
  always_ff @(posedge clk) run_r <= nrst ? run_nxt : 8'h00;

  no_stretch_a:
    assert property (!scl_oe) else $error("target drove the clock line");
  tenbit_nack_a:
    assert property (addr_valid && addr_byte[7:3] == 5'h1e |=> !addr_ack_r)
    else $error("ten-bit prefix acknowledged");
  addr_ack_a:
    assert property (addr_valid && addr_byte[7:1] == target_addr && addr_byte[7:3] != 5'h1e
      && !(addr_byte[7:1] inside {[7'h04:7'h07]}) |=> addr_ack_r)
    else $error("own address not acknowledged");
  hs_enter_a:
    assert property (addr_valid && addr_byte[7:1] inside {[7'h04:7'h07]} |=> hs_active_r)
    else $error("high-speed code did not enter high-speed mode");
  read_answer_a:
    assert property (rd_valid_r |-> $past(stop) && !$past(busy))
    else $error("read answered without an idle frame end");
  busy_cause_a:
    assert property ($rose(busy) |-> $past(stop) || $past(trim_wr_en))
    else $error("busy rose without a write");
  prog_limit_a:
    assert property (busy |-> run_r < PROG_CYCLES) else $error("programming ran too long");
  setup_hold_a:
    assert property (!$past(busy) |-> $stable(target_addr) && $stable(sclk_idle_high)
      && $stable(latch_falling)) else $error("active setup changed after load");
  eoc_cause_a:
    assert property ($rose(eoc_r) |-> $past(conditioned_result_done)) else $error("pin rose without a result");
endmodule

// ---- tb/test_config_memory_and_interface_setup.sv ----
// Purpose: Self-checking bench for the configuration store block
// Assumes: Programming time shortened to PROG cycles
// Notes: Store clears on reset, so word 2 settings stay at defaults here
`timescale 1ns/1ns
module test_config_memory_and_interface_setup;
  localparam int unsigned PROG = 8;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic addr_valid, byte_valid, stop, trim_wr_en, conditioned_result_done, select_pin;
  logic [7:0] addr_byte, byte_data;
  logic [5:0] trim_index;
  logic [15:0] trim_data, rd_data_r;
  logic [23:0] conditioned_result, threshold_one, threshold_two;
  logic addr_ack_r, rd_valid_r, busy, scl_out, scl_oe, eoc_r, spi_selected_r;
  logic sclk_idle_high, latch_falling, hs_active_r;
  logic [31:0] customer_ident_r;
  logic [6:0] target_addr;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  // Write code, data, read code, expected word
  logic [47:0] rows [4] = '{{8'h40, 16'ha5c3, 8'h00, 16'ha5c3},
    {8'h41, 16'h0f0f, 8'h01, 16'h0f0f}, {8'h42, 16'h0eaa, 8'h02, 16'h0eaa},
    {8'h79, 16'h5a5a, 8'h39, 16'h5a5a}};
  always #2 clk = ~clk;
  config_memory_and_interface_setup #(.PROG_CYCLES(PROG)) i_config_memory_and_interface_setup (
    .clk(clk), .nrst(nrst), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .addr_ack_r(addr_ack_r), .byte_valid(byte_valid), .byte_data(byte_data), .stop(stop),
    .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r), .busy(busy), .scl_out(scl_out),
    .scl_oe(scl_oe), .trim_wr_en(trim_wr_en), .trim_index(trim_index),
    .trim_data(trim_data), .conditioned_result_done(conditioned_result_done), .conditioned_result(conditioned_result),
    .threshold_one(threshold_one), .threshold_two(threshold_two), .eoc_r(eoc_r),
    .select_pin(select_pin), .spi_selected_r(spi_selected_r),
    .sclk_idle_high(sclk_idle_high), .latch_falling(latch_falling),
    .customer_ident_r(customer_ident_r), .target_addr(target_addr),
    .hs_active_r(hs_active_r));
  cfg_host_model i_cfg_host_model (.clk(clk), .addr_valid(addr_valid), .addr_byte(addr_byte),
    .byte_valid(byte_valid), .byte_data(byte_data), .stop(stop));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [7:0] code, input logic [15:0] exp);
    i_cfg_host_model.send_cmd(code, 16'h0000, 1);
    chk({15'h0, rd_valid_r, rd_data_r}, {15'h0, 1'b1, exp});
  endtask
  task automatic prog_wait();
    n = 0;
    while (busy === 1'b1 && n < 40) begin
      n++;
      @(posedge clk) #1;
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      test_done();
    end
  end
  initial begin
    {trim_wr_en, conditioned_result_done, select_pin, trim_index, trim_data} = {3'b001, 6'h3a, 16'h7777};
    {conditioned_result, threshold_one, threshold_two} = {24'h000100, 24'h000200, 24'h000300};
    repeat (5) @(posedge clk);
    #1 nrst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk({busy, target_addr, sclk_idle_high, latch_falling, spi_selected_r}, 0);
    chk({scl_out, scl_oe}, 0);
    rd(8'h02, 16'h0000);
    rd(8'h00, 16'h0000);
    chk(customer_ident_r, 0);
    $display("reset test done");
    foreach (rows[i]) begin
      i_cfg_host_model.send_cmd(rows[i][47:40], rows[i][39:24], 3);
      prog_wait();
      chk(n, PROG);
      rd(rows[i][23:16], rows[i][15:0]);
    end
    chk(customer_ident_r, 32'h0f0fa5c3);
    chk(target_addr, 0);
    $display("table test done");
    i_cfg_host_model.send_cmd(8'h7a, 16'hffff, 3);
    chk(busy, 0);
    i_cfg_host_model.send_cmd(8'h43, 16'hffff, 2);
    chk(busy, 0);
    i_cfg_host_model.send_cmd(8'h44, 16'h1111, 3);
    i_cfg_host_model.send_cmd(8'h00, 16'h0000, 1);
    chk(rd_valid_r, 0);
    prog_wait();
    rd(8'h04, 16'h1111);
    @(posedge clk) #1 {trim_wr_en, trim_index} = {1'b1, 6'h00};
    @(posedge clk) #1 trim_wr_en = 1'b0;
    chk(busy, 1);
    prog_wait();
    rd(8'h00, 16'h7777);
    $display("refusal test done");
    i_cfg_host_model.send_addr(8'h00);
    chk(addr_ack_r, 1);
    i_cfg_host_model.send_addr(8'hf0);
    chk(addr_ack_r, 0);
    i_cfg_host_model.send_addr(8'h08);
    chk({addr_ack_r, hs_active_r}, 1);
    i_cfg_host_model.send_cmd(8'h00, 16'h0000, 1);
    chk(rd_valid_r, 0);
    i_cfg_host_model.send_addr(8'h0e);
    i_cfg_host_model.send_cmd(8'h45, 16'h2222, 3);
    chk(busy, 1);
    prog_wait();
    rd(8'h05, 16'h2222);
    $display("address test done");
    @(posedge clk) #1 {conditioned_result_done, select_pin} = 2'b10;
    @(posedge clk) #1 conditioned_result_done = 1'b0;
    chk(eoc_r, 1);
    rd(8'h01, 16'h0f0f);
    chk(eoc_r, 0);
    chk(spi_selected_r, 1);
    $display("pin test done");
    test_done();
  end
endmodule
bind config_memory_and_interface_setup cfg_store_properties #(.PROG_CYCLES(PROG_CYCLES))
  i_cfg_store_properties (.clk(clk), .nrst(nrst), .addr_valid(addr_valid),
  .addr_byte(addr_byte), .addr_ack_r(addr_ack_r), .stop(stop), .rd_valid_r(rd_valid_r),
  .busy(busy), .scl_oe(scl_oe), .trim_wr_en(trim_wr_en), .conditioned_result_done(conditioned_result_done),
  .eoc_r(eoc_r), .sclk_idle_high(sclk_idle_high), .latch_falling(latch_falling),
  .target_addr(target_addr), .hs_active_r(hs_active_r));
